/* hdl/reactive_energy_accumulator.sv */
// reactive power calibration and var-hour accumulation, three phases
// assumes power samples are synchronous to i_ref_clk and the register
// port carries one access per clock from the serial port logic
`timescale 1ns/100ps
`default_nettype none
`include "var_energy_defines.svh"

module reactive_energy_accumulator #(
    parameter int          PW         = 28,
    parameter int unsigned SAMPLE_DIV = `SAMPLE_DIV_CYCLES
) (
    // clock and reset
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_nrst,
    // averaged reactive power: 0..2 total a/b/c, 3..5 fundamental a/b/c
    input  wire logic signed [PW-1:0]  i_var_power [6],
    // register port
    input  wire var_energy_pkg::reg_req_s i_reg,
    output logic [31:0]                o_reg_rdata,
    // active-low interrupt line
    output logic                       o_event_request_n
);
    import var_energy_pkg::*;

    localparam int DW = $clog2(SAMPLE_DIV);

    // ****************************************************************
    // address decode
    // ****************************************************************

    // true when addr falls in the six-word block that starts at base
    function automatic logic in_block(input logic [7:0] addr,
                                      input logic [7:0] base);
        logic [7:0] d;
        d = addr - base;
        in_block = d < 8'h06;
    endfunction

    logic       gain_hit;
    logic       ofs_hit;
    logic       varh_hit;
    logic [2:0] gain_idx;
    logic [2:0] ofs_idx;
    logic [2:0] varh_idx;
    logic [7:0] gain_d;
    logic [7:0] ofs_d;
    logic [7:0] varh_d;
    logic       hit_thr_hi;
    logic       hit_thr_lo;
    logic       hit_mode;
    logic       hit_lcyc;
    logic       hit_status;
    logic       hit_mask;
    logic       hit_sign;

    // block hits and element index inside each block
    assign gain_hit   = in_block(i_reg.addr, `ADDR_TOTAL_GAIN);
    assign ofs_hit    = in_block(i_reg.addr, `ADDR_TOTAL_OFFSET);
    assign varh_hit   = in_block(i_reg.addr, `ADDR_TOTAL_VARH);
    assign gain_d     = i_reg.addr - `ADDR_TOTAL_GAIN;
    assign ofs_d      = i_reg.addr - `ADDR_TOTAL_OFFSET;
    assign varh_d     = i_reg.addr - `ADDR_TOTAL_VARH;
    assign gain_idx   = gain_d[2:0];
    assign ofs_idx    = ofs_d[2:0];
    assign varh_idx   = varh_d[2:0];
    assign hit_thr_hi = i_reg.addr == `ADDR_THR_HIGH;
    assign hit_thr_lo = i_reg.addr == `ADDR_THR_LOW;
    assign hit_mode   = i_reg.addr == `ADDR_ACCUM_MODE;
    assign hit_lcyc   = i_reg.addr == `ADDR_LINE_CYCLE;
    assign hit_status = i_reg.addr == `ADDR_STATUS;
    assign hit_mask   = i_reg.addr == `ADDR_MASK;
    assign hit_sign   = i_reg.addr == `ADDR_PHASE_SIGN;

    // ****************************************************************
    // configuration registers
    // ****************************************************************

    logic [23:0] gain [6];
    logic [23:0] ofs  [6];
    logic [23:0] thr_hi;
    logic [23:0] thr_lo;
    logic [7:0]  accum_mode;
    logic [7:0]  line_cycle_mode;
    logic [31:0] mask;
    logic [47:0] var_energy_threshold;
    logic        read_clear;
    logic        sign_sel;

    // only the low 24 bits of a gain or offset word are kept;
    // the eight top bits of the 32-bit word always read back as zero
    generate
        for (genvar k = 0; k < 6; k++) begin : g_cfg
            always_ff @(posedge i_ref_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    gain[k] <= 24'h000000;
                    ofs[k]  <= 24'h000000;
                end else begin
                    if (i_reg.wr && gain_hit && gain_idx == 3'(k)) begin
                        gain[k] <= i_reg.wdata[23:0];
                    end
                    if (i_reg.wr && ofs_hit && ofs_idx == 3'(k)) begin
                        ofs[k] <= i_reg.wdata[23:0];
                    end
                end
            end
        end
    endgenerate

    // threshold halves, mode bytes and mask
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            thr_hi          <= 24'h000000;
            thr_lo          <= 24'h000000;
            accum_mode      <= 8'h00;
            line_cycle_mode <= 8'h00;
            mask            <= `RST_WORD;
        end else if (i_reg.wr) begin
            if (hit_thr_hi) thr_hi <= i_reg.wdata[23:0];
            if (hit_thr_lo) thr_lo <= i_reg.wdata[23:0];
            if (hit_mode)   accum_mode <= i_reg.wdata[7:0];
            if (hit_lcyc)   line_cycle_mode <= i_reg.wdata[7:0];
            if (hit_mask)   mask <= i_reg.wdata;
        end
    end

    // one threshold feeds every first-stage path
    assign var_energy_threshold = {thr_hi, thr_lo};
    assign sign_sel   = accum_mode[`SIGN_SOURCE_BIT];
    assign read_clear = line_cycle_mode[`READ_CLEAR_BIT];

    // ****************************************************************
    // sample rate divider
    // ****************************************************************

    logic [DW-1:0] div_cnt;
    logic          sample_en;

    // one enable pulse per sample period, no second clock
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            div_cnt   <= '0;
            sample_en <= 1'b0;
        end else begin
            sample_en <= div_cnt == DW'(SAMPLE_DIV - 1);
            div_cnt   <= (div_cnt == DW'(SAMPLE_DIV - 1)) ? '0
                       : div_cnt + DW'(1);
        end
    end

    // ****************************************************************
    // first and second stage per path
    // ****************************************************************

    pulse_s      pulse   [6];
    logic [31:0] varh    [6];
    logic [5:0]  half_ev;
    logic [5:0]  rd_clear;

    generate
        for (genvar k = 0; k < 6; k++) begin : g_path
            // read-with-clear acts on the word just latched for the host
            assign rd_clear[k] = i_reg.rd && read_clear && varh_hit
                               && varh_idx == 3'(k);

            var_power_stage1 #(
                .PW          (PW)
            ) u_stage1 (
                .i_ref_clk   (i_ref_clk),
                .i_nrst      (i_nrst),
                .i_sample_en (sample_en),
                .i_power     (i_var_power[k]),
                .i_gain      (gain[k]),
                .i_offset    (ofs[k]),
                .i_thr       (var_energy_threshold),
                .o_pulse     (pulse[k])
            );

            varh_counter u_varh (
                .i_ref_clk   (i_ref_clk),
                .i_nrst      (i_nrst),
                .i_pulse     (pulse[k]),
                .i_clear     (rd_clear[k]),
                .o_count     (varh[k]),
                .o_half_ev   (half_ev[k])
            );
        end
    endgenerate

    // ****************************************************************
    // sign detection and status
    // ****************************************************************

    logic [2:0]  sign_change;
    logic [2:0]  phase_sign;
    logic [2:0]  sign_set;
    logic [2:0]  sel_fire;
    logic [2:0]  sel_neg;
    logic        half_total;
    logic        half_fund;
    logic [31:0] w1c;
    logic [31:0] status_word;
    logic [31:0] sign_word;

    // per phase, pick the monitored path and compare against last sign
    generate
        for (genvar p = 0; p < 3; p++) begin : g_sign
            assign sel_fire[p] = sign_sel ? pulse[p+3].fire
                                          : pulse[p].fire;
            assign sel_neg[p]  = sign_sel ? pulse[p+3].neg
                                          : pulse[p].neg;
            assign sign_set[p] = sel_fire[p]
                               && (sel_neg[p] != phase_sign[p]);
        end
    endgenerate

    assign w1c = (i_reg.wr && hit_status) ? i_reg.wdata : 32'h0;
    assign status_word = {19'h0, sign_change, 6'h0,
                          half_fund, half_total, 2'h0};
    assign sign_word   = {25'h0, phase_sign, 4'h0};

    // a set arriving with its clear wins so no event is lost
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sign_change <= 3'h0;
            phase_sign  <= 3'h0;
            half_total  <= 1'b0;
            half_fund   <= 1'b0;
        end else begin
            sign_change <= sign_set | (sign_change
                         & ~w1c[`STAT_SIGN_LSB +: 3]);
            for (int p = 0; p < 3; p++) begin
                if (sel_fire[p]) phase_sign[p] <= sel_neg[p];
            end
            half_total  <= (|half_ev[2:0])
                         | (half_total & ~w1c[`STAT_TOTAL_HALF]);
            half_fund   <= (|half_ev[5:3])
                         | (half_fund & ~w1c[`STAT_FUND_HALF]);
        end
    end

    // ****************************************************************
    // interrupt line and read data
    // ****************************************************************

    logic [31:0] rd_word;

    // read mux; unmapped words read as zero
    assign rd_word = gain_hit   ? {8'h0, gain[gain_idx]}
                   : ofs_hit    ? {8'h0, ofs[ofs_idx]}
                   : varh_hit   ? varh[varh_idx]
                   : hit_thr_hi ? {8'h0, thr_hi}
                   : hit_thr_lo ? {8'h0, thr_lo}
                   : hit_mode   ? {24'h0, accum_mode}
                   : hit_lcyc   ? {24'h0, line_cycle_mode}
                   : hit_status ? status_word
                   : hit_mask   ? mask
                   : hit_sign   ? sign_word : 32'h0;

    // line is low while any enabled bit pends; one clock behind status
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_reg_rdata       <= `RST_WORD;
            o_event_request_n <= 1'b1;
        end else begin
            if (i_reg.rd) o_reg_rdata <= rd_word;
            o_event_request_n <= ~|(status_word & mask);
        end
    end

    property p_irq_low;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (|(status_word & mask)) |=> !o_event_request_n;
    endproperty
    a_irq_low: assert property (p_irq_low)
        else $error("enabled pending bit did not pull line low");

    property p_irq_high;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        !(|(status_word & mask)) |=> o_event_request_n;
    endproperty
    a_irq_high: assert property (p_irq_high)
        else $error("line low with nothing enabled pending");

    property p_half_irq;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (half_ev[0] && mask[`STAT_TOTAL_HALF])
        |=> half_total ##1 !o_event_request_n;
    endproperty
    a_half_irq: assert property (p_half_irq)
        else $error("half-full event did not reach the line");

    property p_w1c;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (w1c[`STAT_SIGN_LSB] && !sign_set[0]) |=> !sign_change[0];
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("write one did not clear phase a flag");

    property p_sign_with_flag;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        $rose(sign_change[0]) |-> phase_sign[0] != $past(phase_sign[0]);
    endproperty
    a_sign_with_flag: assert property (p_sign_with_flag)
        else $error("flag set without phase sign flip");

    property p_read_clear;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        rd_clear[0] |=> (varh[0] == 32'h0 || varh[0] == 32'h1
                         || varh[0] == 32'hFFFF_FFFF);
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("accumulator not cleared after read");

endmodule
`default_nettype wire

/* hdl/var_energy_defines.svh */
// register offsets, field positions, reset values and timing counts
// assumes inclusion by the package and by every design file of the block
`ifndef VAR_ENERGY_DEFINES_SVH
`define VAR_ENERGY_DEFINES_SVH

// ****************************************************************
// register offsets (word index on the register port)
// ****************************************************************
`define ADDR_TOTAL_GAIN    8'h00
`define ADDR_FUND_GAIN     8'h03
`define ADDR_TOTAL_OFFSET  8'h06
`define ADDR_FUND_OFFSET   8'h09
`define ADDR_THR_HIGH      8'h0C
`define ADDR_THR_LOW       8'h0D
`define ADDR_TOTAL_VARH    8'h0E
`define ADDR_FUND_VARH     8'h11
`define ADDR_ACCUM_MODE    8'h14
`define ADDR_LINE_CYCLE    8'h15
`define ADDR_STATUS        8'h16
`define ADDR_MASK          8'h17
`define ADDR_PHASE_SIGN    8'h18

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define SIGN_SOURCE_BIT    7
`define READ_CLEAR_BIT     6
`define STAT_SIGN_LSB      10
`define STAT_TOTAL_HALF    2
`define STAT_FUND_HALF     3
`define PHASE_SIGN_REG_LSB         4
`define HALF_FULL_BIT      30
`define GAIN_FRAC_BITS     23
`define RST_WORD           32'h0000_0000

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_NS      10
`define SAMPLE_PERIOD_NS   125000
`define SAMPLE_DIV_CYCLES  (`SAMPLE_PERIOD_NS / `CLK_PERIOD_NS)

`endif

/* hdl/var_energy_pkg.sv */
// types shared by the reactive energy block
// assumes the defines header sits beside it
`include "var_energy_defines.svh"

package var_energy_pkg;

    // one register port access, taken in one clock
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } reg_req_s;

    // first-stage energy pulse and its sign
    typedef struct packed {
        logic fire;
        logic neg;
    } pulse_s;

endpackage

/* hdl/var_power_stage1.sv */
// calibration and first-stage threshold integration for one path
// assumes a one-cycle sample enable at the 8 kHz rate
`timescale 1ns/100ps
`default_nettype none
`include "var_energy_defines.svh"

module var_power_stage1 #(
    parameter int PW = 28
) (
    // clock and reset
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_nrst,
    // sample and calibration
    input  wire logic                  i_sample_en,
    input  wire logic signed [PW-1:0]  i_power,
    input  wire logic [23:0]           i_gain,
    input  wire logic [23:0]           i_offset,
    input  wire logic [47:0]           i_thr,
    // energy pulse
    output var_energy_pkg::pulse_s     o_pulse
);
    import var_energy_pkg::*;

    logic signed [47:0]      acc;
    logic signed [27:0]      gain_s;
    logic signed [27:0]      ofs_s;
    logic signed [PW+27:0]   prod;
    logic signed [47:0]      cal;
    logic signed [47:0]      sum;
    logic signed [47:0]      thr_s;
    logic                    hit_pos;
    logic                    hit_neg;

    // sign extension to the 28-bit core width, then (1+g/2^23) and offset
    assign gain_s  = $signed({{4{i_gain[23]}}, i_gain});
    assign ofs_s   = $signed({{4{i_offset[23]}}, i_offset});
    assign prod    = i_power * gain_s;
    assign cal     = 48'(i_power) + 48'(prod >>> `GAIN_FRAC_BITS)
                   + 48'(ofs_s);
    assign thr_s   = $signed(i_thr);
    assign sum     = acc + cal;
    // positive side wins at a zero threshold
    assign hit_pos = sum >= thr_s;
    assign hit_neg = !hit_pos && (sum <= -thr_s);

    // integrate at the sample rate, take the threshold out on a pulse
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            acc     <= '0;
            o_pulse <= '0;
        end else begin
            o_pulse.fire <= i_sample_en && (hit_pos || hit_neg);
            o_pulse.neg  <= i_sample_en && hit_neg;
            if (i_sample_en) begin
                acc <= hit_pos ? sum - thr_s
                     : hit_neg ? sum + thr_s : sum;
            end
        end
    end

    property p_pulse_on_sample;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        o_pulse.fire |-> $past(i_sample_en);
    endproperty
    a_pulse_on_sample: assert property (p_pulse_on_sample)
        else $error("pulse without a sample");

    property p_hold_between;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        !i_sample_en |=> acc == $past(acc);
    endproperty
    a_hold_between: assert property (p_hold_between)
        else $error("accumulator moved between samples");

    property p_neutral_gain;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (i_gain == 24'h000000) |-> cal == 48'(i_power) + 48'(ofs_s);
    endproperty
    a_neutral_gain: assert property (p_neutral_gain)
        else $error("offset not applied at unity gain");

    property p_half_gain;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (i_gain == 24'hC00000 && i_offset == 24'h000000 && !i_power[0])
        |-> cal + cal == 48'(i_power);
    endproperty
    a_half_gain: assert property (p_half_gain)
        else $error("gain 0xC00000 did not halve power");

endmodule
`default_nettype wire

/* hdl/varh_counter.sv */
// second-stage signed var-hour counter with half-full detection
// assumes pulses arrive one clock wide from the first stage
`timescale 1ns/100ps
`default_nettype none
`include "var_energy_defines.svh"

module varh_counter (
    // clock and reset
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_nrst,
    // pulse in, clear on read
    input  wire var_energy_pkg::pulse_s i_pulse,
    input  wire logic                  i_clear,
    // count and half-full event
    output logic [31:0]                o_count,
    output logic                       o_half_ev
);
    import var_energy_pkg::*;

    logic [31:0] base;
    logic [31:0] next_count;

    // clear first so a pulse in the read cycle still counts
    assign base       = i_clear ? 32'h0000_0000 : o_count;
    // plain modulo arithmetic gives both full-scale wraps
    assign next_count = !i_pulse.fire ? base
                      : i_pulse.neg ? base - 32'h0000_0001
                      : base + 32'h0000_0001;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_count   <= `RST_WORD;
            o_half_ev <= 1'b0;
        end else begin
            o_count   <= next_count;
            o_half_ev <= i_pulse.fire && (next_count[`HALF_FULL_BIT]
                         != base[`HALF_FULL_BIT]);
        end
    end

    property p_count_up;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (i_pulse.fire && !i_pulse.neg && !i_clear)
        |=> o_count == $past(o_count) + 32'h0000_0001;
    endproperty
    a_count_up: assert property (p_count_up)
        else $error("positive pulse not counted");

    property p_count_down;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (i_pulse.fire && i_pulse.neg && !i_clear)
        |=> o_count == $past(o_count) - 32'h0000_0001;
    endproperty
    a_count_down: assert property (p_count_down)
        else $error("negative pulse not subtracted");

    property p_half_flag;
        @(posedge i_ref_clk) disable iff (!i_nrst)
        o_half_ev |-> o_count[30] != $past(o_count[30]) || $past(i_clear);
    endproperty
    a_half_flag: assert property (p_half_flag)
        else $error("half-full event without bit 30 change");

endmodule
`default_nettype wire

/* tb/host_model.sv */
// host model: register port master, one access per call
// assumes read data follows one cycle after the taking edge
`timescale 1ns/100ps
`default_nettype none
module host_model (
    // clock and read data
    input  wire logic               i_ref_clk,
    input  wire logic [31:0]        i_rdata,
    // register requests
    output var var_energy_pkg::reg_req_s o_reg
);
    import var_energy_pkg::*;
    initial o_reg = '0;
    // whole 32-bit words only; strobe held through the taking edge
    task automatic access(input logic w, input logic [7:0] a,
                          input logic [31:0] d, output logic [31:0] q);
        @(posedge i_ref_clk);
        o_reg <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge i_ref_clk);
        o_reg <= '0;
        @(posedge i_ref_clk);
        #1 q = i_rdata;
    endtask
endmodule
`default_nettype wire

/* tb/reactive_energy_accumulator_tb_top.sv */
// self-checking bench for the reactive energy accumulator
// assumes the host model owns the register port
`timescale 1ns/100ps
`default_nettype none
`include "var_energy_defines.svh"
module reactive_energy_accumulator_tb_top;
    import var_energy_pkg::*;
    logic               i_ref_clk = 1'b0;
    logic               i_nrst    = 1'b0;
    logic signed [27:0] pw [6]    = '{default: '0};
    reg_req_s           req;
    logic [31:0]        rdata, q;
    logic               irq_n;
    int                 err_count = 0, tests_run = 0, cyc = 0;
    always #5 i_ref_clk = ~i_ref_clk;
    // short sample divider keeps every window a few cycles long
    reactive_energy_accumulator #(.PW(28), .SAMPLE_DIV(8))
        reactive_energy_accumulator_inst (.i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst), .i_var_power(pw), .i_reg(req),
        .o_reg_rdata(rdata), .o_event_request_n(irq_n));
    host_model host_model_inst (.i_ref_clk(i_ref_clk),
        .i_rdata(rdata), .o_reg(req));
    // ******************************************************
    // checks and scenarios
    // ******************************************************
    always @(posedge i_ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] s, e, input string n);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("wrong value %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host_model_inst.access(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string n);
        host_model_inst.access(1'b0, a, 32'h0, q);
        chk(q, e, n);
    endtask
    task automatic t_pad();
        // largest legal high word: a negative threshold would pump
        // every first-stage accumulator and spoil later counts
        wr(`ADDR_THR_HIGH, 32'hFF7FFFFF);
        rd(`ADDR_THR_HIGH, 32'h007FFFFF, "thr high");
        wr(`ADDR_TOTAL_GAIN, 32'hFFFFFFFF);
        rd(`ADDR_TOTAL_GAIN, 32'h00FFFFFF, "gain");
        wr(`ADDR_THR_HIGH, 32'h0);
        rd(8'hF0, 32'h0, "unmapped");
    endtask
    // reads 80 cycles apart: exactly ten samples in the window
    task automatic t_rate(input logic [23:0] g, o, input logic [27:0] p,
                          input logic [31:0] thr, e);
        wr(`ADDR_TOTAL_GAIN, {8'h00, g});
        wr(`ADDR_FUND_GAIN, {8'h00, g});
        wr(`ADDR_TOTAL_OFFSET, {8'h00, o});
        wr(`ADDR_FUND_OFFSET, {8'h00, o});
        wr(`ADDR_THR_LOW, thr);
        pw[0] <= p;
        pw[3] <= p;
        repeat (40) @(posedge i_ref_clk);
        host_model_inst.access(1'b0, `ADDR_TOTAL_VARH, 32'h0, q);
        host_model_inst.access(1'b0, `ADDR_FUND_VARH, 32'h0, q);
        repeat (74) @(posedge i_ref_clk);
        rd(`ADDR_TOTAL_VARH, e, "total varh");
        rd(`ADDR_FUND_VARH, e, "fund varh");
    endtask
    task automatic t_sign();
        chk(32'(irq_n), 32'h0, "irq low");
        // cleared counters stepping 0 to -1 flip bit 30: both half bits
        rd(`ADDR_STATUS, 32'h40C, "status");
        rd(`ADDR_PHASE_SIGN, 32'h10, "sign");
        // only the sign flag is cleared; zeros leave half bits pending
        wr(`ADDR_STATUS, 32'h400);
        repeat (2) @(posedge i_ref_clk);
        chk(32'(irq_n), 32'h1, "irq high");
        wr(`ADDR_ACCUM_MODE, 32'h80);
        pw[0] <= 28'sd100;
        repeat (40) @(posedge i_ref_clk);
        rd(`ADDR_STATUS, 32'h00C, "status");
        pw[3] <= 28'sd100;
        repeat (40) @(posedge i_ref_clk);
        rd(`ADDR_STATUS, 32'h40C, "status");
        rd(`ADDR_PHASE_SIGN, 32'h0, "sign");
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        rd(`ADDR_STATUS, 32'h0, "status");
        chk(32'(irq_n), 32'h1, "irq");
        t_pad();
        wr(`ADDR_LINE_CYCLE, 32'h40);
        wr(`ADDR_MASK, 32'h400);
        t_rate(24'h0, 24'h0, 28'sd100, 32'd100, 32'd10);
        t_rate(24'h0, 24'h0, -28'sd100, 32'd100, -32'sd10);
        t_sign();
        t_rate(24'h400000, 24'h0, 28'sd100, 32'd150, 32'd10);
        t_rate(24'hC00000, 24'h0, 28'sd200, 32'd100, 32'd10);
        t_rate(24'h0, 24'd50, 28'sd50, 32'd100, 32'd10);
        report_and_stop();
    end
endmodule
`default_nettype wire
